// file: rtl/ccd_regs.vh
// ccd_regs.vh: constants of the core datapath: opcodes, fields, I/O offsets.
// Included by the core module, the checker and the bench top, not by the register file, multiplier or memory model; definitions only.
`ifndef CCD_REGS_VH
`define CCD_REGS_VH
// Major opcodes in instruction bits 15:12
`define CCD_OP_ARA 4'h0
`define CCD_OP_ARB 4'h1
`define CCD_OP_CMP 4'h2
`define CCD_OP_MUL 4'h3
`define CCD_OP_SUBTRACT_IMM_OP 4'h4
`define CCD_OP_SUBTRACT_CARRY_IMM_OP 4'h5
`define CCD_OP_CPI 4'h6
`define CCD_OP_AND_IMM_OP 4'h7
`define CCD_OP_ORI 4'h8
`define CCD_OP_LDI 4'h9
`define CCD_OP_LDST 4'hA
`define CCD_OP_STK 4'hB
`define CCD_OP_RELATIVE_CALL_OP 4'hC
`define CCD_OP_CALL 4'hD
`define CCD_OP_BR 4'hE
`define CCD_OP_NOP 16'hF000
// ALU functions
`define CCD_FN_ADD 3'h0
`define CCD_FN_ADC 3'h1
`define CCD_FN_SUB 3'h2
`define CCD_FN_SBC 3'h3
`define CCD_FN_AND 3'h4
`define CCD_FN_OR 3'h5
`define CCD_FN_EOR 3'h6
`define CCD_FN_MOV 3'h7
// Stack group sub-operations in bits 6:4
`define CCD_SK_PUSH 3'h0
`define CCD_SK_POP 3'h1
`define CCD_SK_RET 3'h2
`define CCD_SK_INTERRUPT_EXIT_OP 3'h3
`define CCD_SK_INDIRECT_CALL_OP 3'h4
`define CCD_SK_LPM 3'h5
`define CCD_SK_SEI 3'h6
`define CCD_SK_CLI 3'h7
// Pointer addressing modes in bits 3:2
`define CCD_AM_PLAIN 2'h0
`define CCD_AM_POSTINC 2'h1
`define CCD_AM_PREDEC 2'h2
`define CCD_AM_DISP 2'h3
// Status flag bit positions
`define CCD_F_C 0
`define CCD_F_Z 1
`define CCD_F_N 2
`define CCD_F_V 3
`define CCD_F_S 4
`define CCD_F_H 5
`define CCD_F_T 6
`define CCD_F_I 7
// Core I/O registers in data space and reset values
`define CCD_IO_SPL 16'h003D
`define CCD_IO_SPH 16'h003E
`define CCD_IO_STATUS_FLAG_REGISTER 16'h003F
`define CCD_IO_TOP 16'h0040
`define CCD_SP_RESET 16'h3FFF
`define CCD_PC_RESET 16'h0000
`define CCD_STATUS_FLAG_REGISTER_RESET 8'h00
`define CCD_IRQ_BLOCK 3'h4
`define CCD_PAIR_X 4'hD
`endif

// file: rtl/ccd_regfile.v
// ccd_regfile.v: 32 x 8 working registers with pointer pair outputs.
// Assumes one byte write and one pair write per cycle from the core.
`timescale 1ns/1ps
`default_nettype none
module ccd_regfile (
	input wire mclk,
	input wire rst,
	input wire [4:0] rdAddrA,
	input wire [4:0] rdAddrB,
	output wire [7:0] rdDataA,
	output wire [7:0] rdDataB,
	input wire wrEn,
	input wire [4:0] wrAddr,
	input wire [7:0] wrData,
	input wire pairWrEn,
	input wire [3:0] pairWrIdx,
	input wire [15:0] pairWrData,
	output wire [15:0] ptrX,
	output wire [15:0] ptrY,
	output wire [15:0] ptrZ
);
	wire [255:0] flat;
	genvar i;
	// Separate space from data memory: reached only by register index
	generate
		for (i = 0; i < 32; i = i + 1) begin : gEntry
			localparam [4:0] IDX = i;
			reg [7:0] q;
			always @(posedge mclk or posedge rst) begin
				if (rst) begin
					q <= 8'h00;
				end else if (pairWrEn && (pairWrIdx == IDX[4:1])) begin
					q <= IDX[0] ? pairWrData[15:8] : pairWrData[7:0];
				end else if (wrEn && (wrAddr == IDX)) begin
					q <= wrData;
				end
			end
			assign flat[i * 8 +: 8] = q;
		end
	endgenerate
	assign rdDataA = flat[{rdAddrA, 3'b000} +: 8];
	assign rdDataB = flat[{rdAddrB, 3'b000} +: 8];
	// Lower register is the low byte of each pair
	assign ptrX = flat[223:208];
	assign ptrY = flat[239:224];
	assign ptrZ = flat[255:240];
endmodule
`default_nettype wire

// file: rtl/ccd_mult.v
// ccd_mult.v: 8x8 multiplier, operands captured at issue, product next cycle.
// Assumes the core holds off a new start until the product is consumed.
`timescale 1ns/1ps
`default_nettype none
module ccd_mult (
	input wire mclk,
	input wire rst,
	input wire start,
	input wire [7:0] mulA,
	input wire [7:0] mulB,
	input wire [2:0] variant,
	output wire [15:0] product,
	output wire carry
);
	reg [8:0] a9;
	reg [8:0] b9;
	reg frac;
	// Variants: 0 uu, 1 ss, 2 su, 3 frac uu, 4 frac ss, 5 frac su
	wire signA = (variant == 3'h1) | (variant == 3'h2) | (variant == 3'h4) | (variant == 3'h5);
	wire signB = (variant == 3'h1) | (variant == 3'h4);
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			a9 <= 9'h000;
			b9 <= 9'h000;
			frac <= 1'b0;
		end else if (start) begin
			a9 <= {signA & mulA[7], mulA};
			b9 <= {signB & mulB[7], mulB};
			frac <= variant >= 3'h3;
		end
	end
	wire signed [17:0] full = $signed(a9) * $signed(b9);
	wire [15:0] raw = full[15:0];
	assign carry = raw[15];
	// Fractional result is shifted left; carry still reflects bit 15 before the shift
	assign product = frac ? {raw[14:0], 1'b0} : raw;
endmodule
`default_nettype wire

// file: rtl/ccd_core.v
// ccd_core.v: 8-bit core execution datapath with prefetch pipeline and stack.
// Assumes asynchronous-read program and data memories, irqReq on mclk.
//
// What this block does
// - Prefetch next word while executing current
// - Stages stall for interrupt entry and multi-cycle ops
// - Thirty-two 8-bit registers, separate space
// - Register ALU ops complete in one cycle
// - ALU ops other than MOV update status flags
// - Interrupts never save or restore flags
// - 8x8 multiply, signed/unsigned/mixed/fractional
// - Multiply takes exactly two cycles
// - First fetch comes from address zero
// - One- and two-word instructions, word PC
// - Stack pointer resets to SRAM top
// - Stack pointer as two I/O bytes
// - Push decrements, pop increments by one
// - Call or interrupt pushes, SP minus two
// - Low byte first, higher address, word address
// - Returns pop PC, SP plus two
// - Low SP write blocks interrupts briefly
// - Immediate ops target registers 16 to 31
// - Registers 26-31 form three pointers
// - Lower register holds pointer low byte
// - Pointer displacement, post-increment, pre-decrement
// - Stack pointer bytes pass through temporary
`timescale 1ns/1ps
`default_nettype none
`include "ccd_regs.vh"
module ccd_core (
	input wire mclk,
	input wire rst,
	output wire [15:0] progAddr,
	input wire [15:0] progData,
	output wire [15:0] dataAddr,
	output wire [7:0] dataWdata,
	output wire dataWe,
	output wire dataRe,
	input wire [7:0] dataRdata,
	input wire irqReq,
	input wire [15:0] irqVector,
	output wire irqAck,
	output wire irqReturn,
	output wire [7:0] statusFlags,
	output wire [15:0] stackPointer
);
	localparam S_EXEC = 3'h0;
	localparam S_MUL = 3'h1;
	localparam S_LPM = 3'h2;
	localparam S_CALL2 = 3'h3;
	localparam S_RET2 = 3'h4;
	reg [2:0] state;
	reg [15:0] pc;
	reg [15:0] ir;
	reg irValid;
	reg [15:0] sp;
	reg [7:0] status_flag_register;
	reg [7:0] spTemp;
	reg [2:0] blockCnt;
	reg [15:0] target;
	reg [7:0] retHi;
	reg [4:0] lpmReg;
	// ****************************************
	// Decode
	// ****************************************
	wire [3:0] major = ir[15:12];
	wire [2:0] sub = ir[6:4];
	wire [1:0] ptrSel = ir[5:4];
	wire [1:0] ldMode = ir[3:2];
	wire isImm = (major >= `CCD_OP_SUBTRACT_IMM_OP) && (major <= `CCD_OP_LDI);
	wire isMul = major == `CCD_OP_MUL;
	wire isStk = major == `CCD_OP_STK;
	// Immediate and multiply forms only carry a 4-bit register field
	wire [4:0] rdA5 = (isImm | isMul) ? {1'b1, ir[11:8]} : ir[11:7];
	wire [4:0] rdB5 = isMul ? {1'b1, ir[7:4]} : ir[6:2];
	wire [7:0] opA;
	wire [7:0] opB;
	wire [15:0] ptrX;
	wire [15:0] ptrY;
	wire [15:0] ptrZ;
	wire [15:0] ptr = (ptrSel == 2'h0) ? ptrX : ((ptrSel == 2'h1) ? ptrY : ptrZ);
	wire run = (state == S_EXEC) & irValid;
	wire takeIrq = run & irqReq & status_flag_register[`CCD_F_I] & (blockCnt == 3'h0);
	wire exec = run & ~takeIrq;
	wire [15:0] spInc = sp + 16'h0001;
	wire [15:0] spDec = sp - 16'h0001;
	wire [15:0] irqRet = pc - 16'h0001;
	wire [15:0] callRet = (major == `CCD_OP_CALL) ? (pc + 16'h0001) : pc;
	wire isCall = (major == `CCD_OP_RELATIVE_CALL_OP) | (major == `CCD_OP_CALL) |
		(isStk & (sub == `CCD_SK_INDIRECT_CALL_OP));
	wire brTaken = status_flag_register[ir[10:8]] == ir[11];
	wire [15:0] mulProd;
	wire mulCarry;
	// ****************************************
	// ALU
	// ****************************************
	reg [2:0] aluFn;
	reg aluWb;
	reg aluFlagWe;
	always @* begin
		aluFn = `CCD_FN_MOV;
		aluWb = 1'b0;
		aluFlagWe = 1'b0;
		case (major)
			`CCD_OP_ARA: begin
				aluFn = {1'b0, ir[1:0]};
				aluWb = 1'b1;
				aluFlagWe = 1'b1;
			end
			`CCD_OP_ARB: begin
				aluFn = {1'b1, ir[1:0]};
				aluWb = 1'b1;
				aluFlagWe = ir[1:0] != 2'h3;
			end
			`CCD_OP_CMP: begin
				aluFn = ir[0] ? `CCD_FN_SBC : `CCD_FN_SUB;
				aluFlagWe = 1'b1;
			end
			`CCD_OP_SUBTRACT_IMM_OP, `CCD_OP_SUBTRACT_CARRY_IMM_OP: begin
				aluFn = (major == `CCD_OP_SUBTRACT_CARRY_IMM_OP) ? `CCD_FN_SBC : `CCD_FN_SUB;
				aluWb = 1'b1;
				aluFlagWe = 1'b1;
			end
			`CCD_OP_CPI: begin
				aluFn = `CCD_FN_SUB;
				aluFlagWe = 1'b1;
			end
			`CCD_OP_AND_IMM_OP, `CCD_OP_ORI: begin
				aluFn = (major == `CCD_OP_AND_IMM_OP) ? `CCD_FN_AND : `CCD_FN_OR;
				aluWb = 1'b1;
				aluFlagWe = 1'b1;
			end
			`CCD_OP_LDI: begin
				aluWb = 1'b1;
			end
			default: begin
			end
		endcase
	end
	wire [7:0] aluB = isImm ? ir[7:0] : opB;
	wire cin = ((aluFn == `CCD_FN_ADC) | (aluFn == `CCD_FN_SBC)) & status_flag_register[`CCD_F_C];
	wire [8:0] sum = {1'b0, opA} + {1'b0, aluB} + {8'h00, cin};
	wire [8:0] dif = {1'b0, opA} - {1'b0, aluB} - {8'h00, cin};
	reg [7:0] aluRes;
	reg [7:0] aluFlags;
	reg fv;
	reg fh;
	reg fc;
	always @* begin
		fv = 1'b0;
		fh = status_flag_register[`CCD_F_H];
		fc = status_flag_register[`CCD_F_C];
		case (aluFn)
			`CCD_FN_ADD, `CCD_FN_ADC: begin
				aluRes = sum[7:0];
				fc = sum[8];
				fh = (opA[3] & aluB[3]) | (aluB[3] & ~sum[3]) | (~sum[3] & opA[3]);
				fv = (opA[7] & aluB[7] & ~sum[7]) | (~opA[7] & ~aluB[7] & sum[7]);
			end
			`CCD_FN_SUB, `CCD_FN_SBC: begin
				aluRes = dif[7:0];
				fc = dif[8];
				fh = (~opA[3] & aluB[3]) | (aluB[3] & dif[3]) | (dif[3] & ~opA[3]);
				fv = (opA[7] & ~aluB[7] & ~dif[7]) | (~opA[7] & aluB[7] & dif[7]);
			end
			`CCD_FN_AND: aluRes = opA & aluB;
			`CCD_FN_OR: aluRes = opA | aluB;
			`CCD_FN_EOR: aluRes = opA ^ aluB;
			default: aluRes = aluB;
		endcase
		aluFlags = status_flag_register;
		aluFlags[`CCD_F_C] = fc;
		aluFlags[`CCD_F_H] = fh;
		aluFlags[`CCD_F_V] = fv;
		aluFlags[`CCD_F_N] = aluRes[7];
		aluFlags[`CCD_F_S] = aluRes[7] ^ fv;
		// Carry-chained subtract keeps Z cleared across the bytes of a wide compare
		aluFlags[`CCD_F_Z] = (aluRes == 8'h00) &
			((aluFn != `CCD_FN_SBC) | status_flag_register[`CCD_F_Z]);
	end
	// ****************************************
	// Data bus request and I/O decode
	// ****************************************
	reg [15:0] memAddr;
	reg [7:0] memWdata;
	reg memWe;
	reg memRe;
	always @* begin
		memAddr = sp;
		memWdata = opA;
		memWe = 1'b0;
		memRe = 1'b0;
		if (takeIrq) begin
			memWe = 1'b1;
			memWdata = irqRet[7:0];
		end else if (exec && (major == `CCD_OP_LDST)) begin
			memWe = ir[6];
			memRe = ~ir[6];
			if (ldMode == `CCD_AM_PREDEC) begin
				memAddr = ptr - 16'h0001;
			end else if (ldMode == `CCD_AM_DISP) begin
				memAddr = ptr + progData;
			end else begin
				memAddr = ptr;
			end
		end else if (exec && isCall) begin
			memWe = 1'b1;
			memWdata = callRet[7:0];
		end else if (exec && isStk) begin
			memWe = sub == `CCD_SK_PUSH;
			memRe = (sub == `CCD_SK_POP) | (sub == `CCD_SK_RET) | (sub == `CCD_SK_INTERRUPT_EXIT_OP);
			if (memRe) begin
				memAddr = spInc;
			end
		end else if (state == S_CALL2) begin
			memWe = 1'b1;
			memWdata = retHi;
		end else if (state == S_RET2) begin
			memAddr = spInc;
			memRe = 1'b1;
		end
	end
	wire ioSpl = memAddr == `CCD_IO_SPL;
	wire ioSph = memAddr == `CCD_IO_SPH;
	wire ioSreg = memAddr == `CCD_IO_STATUS_FLAG_REGISTER;
	wire ioHit = ioSpl | ioSph | ioSreg;
	wire ioWrite = memWe & (memAddr < `CCD_IO_TOP);
	wire [7:0] rdData = ioSpl ? sp[7:0] : (ioSph ? spTemp : (ioSreg ? status_flag_register : dataRdata));
	assign dataAddr = memAddr;
	assign dataWdata = memWdata;
	assign dataWe = memWe & ~ioHit;
	assign dataRe = memRe & ~ioHit;
	// Program bus only ever carries fetches and program-memory loads
	assign progAddr = (state == S_LPM) ? {1'b0, ptrZ[15:1]} : pc;
	assign irqAck = takeIrq;
	assign irqReturn = exec & isStk & (sub == `CCD_SK_INTERRUPT_EXIT_OP);
	assign statusFlags = status_flag_register;
	assign stackPointer = sp;
	// ****************************************
	// Register file write selection
	// ****************************************
	reg rfWe;
	reg [4:0] rfAddr;
	reg [7:0] rfData;
	reg pairWe;
	reg [3:0] pairIdx;
	reg [15:0] pairData;
	always @* begin
		rfWe = 1'b0;
		rfAddr = ir[11:7];
		rfData = rdData;
		pairWe = 1'b0;
		pairIdx = `CCD_PAIR_X + {2'b00, ptrSel};
		pairData = (ldMode == `CCD_AM_POSTINC) ? (ptr + 16'h0001) : (ptr - 16'h0001);
		if (exec && aluWb) begin
			rfWe = 1'b1;
			rfAddr = rdA5;
			rfData = aluRes;
		end else if (exec && (major == `CCD_OP_LDST)) begin
			rfWe = ~ir[6];
			pairWe = (ldMode == `CCD_AM_POSTINC) | (ldMode == `CCD_AM_PREDEC);
		end else if (exec && isStk && (sub == `CCD_SK_POP)) begin
			rfWe = 1'b1;
		end else if (state == S_LPM) begin
			rfWe = 1'b1;
			rfAddr = lpmReg;
			rfData = ptrZ[0] ? progData[15:8] : progData[7:0];
		end else if (state == S_MUL) begin
			pairWe = 1'b1;
			pairIdx = 4'h0;
			pairData = mulProd;
		end
	end
	ccd_regfile uRegs (
		.mclk(mclk),
		.rst(rst),
		.rdAddrA(rdA5),
		.rdAddrB(rdB5),
		.rdDataA(opA),
		.rdDataB(opB),
		.wrEn(rfWe),
		.wrAddr(rfAddr),
		.wrData(rfData),
		.pairWrEn(pairWe),
		.pairWrIdx(pairIdx),
		.pairWrData(pairData),
		.ptrX(ptrX),
		.ptrY(ptrY),
		.ptrZ(ptrZ)
	);
	ccd_mult uMult (
		.mclk(mclk),
		.rst(rst),
		.start(exec & isMul),
		.mulA(opA),
		.mulB(opB),
		.variant(ir[2:0]),
		.product(mulProd),
		.carry(mulCarry)
	);
	// ****************************************
	// Sequencer
	// ****************************************
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= S_EXEC;
			pc <= `CCD_PC_RESET;
			ir <= `CCD_OP_NOP;
			irValid <= 1'b0;
			sp <= `CCD_SP_RESET;
			status_flag_register <= `CCD_STATUS_FLAG_REGISTER_RESET;
			spTemp <= 8'h00;
			blockCnt <= 3'h0;
			target <= 16'h0000;
			retHi <= 8'h00;
			lpmReg <= 5'h00;
		end else begin
			case (state)
				S_EXEC: begin
					if (takeIrq) begin
						// Flags stay as they are across handler entry
						sp <= spDec;
						retHi <= irqRet[15:8];
						target <= irqVector;
						state <= S_CALL2;
					end else begin
						pc <= pc + 16'h0001;
						ir <= progData;
						irValid <= 1'b1;
						if (exec && aluFlagWe) begin
							status_flag_register <= aluFlags;
						end
						if (exec && isCall) begin
							sp <= spDec;
							retHi <= callRet[15:8];
							state <= S_CALL2;
							if (major == `CCD_OP_RELATIVE_CALL_OP) begin
								target <= pc + {{4{ir[11]}}, ir[11:0]};
							end else if (major == `CCD_OP_CALL) begin
								target <= progData;
							end else begin
								target <= ptrZ;
							end
						end
						if (exec && isMul) begin
							state <= S_MUL;
						end
						// Second word is consumed here, so its slot becomes a bubble
						if (exec && (major == `CCD_OP_LDST) && (ldMode == `CCD_AM_DISP)) begin
							irValid <= 1'b0;
						end
						if (exec && (major == `CCD_OP_BR) && brTaken) begin
							pc <= pc + {{8{ir[7]}}, ir[7:0]};
							irValid <= 1'b0;
						end
						if (exec && isStk) begin
							case (sub)
								`CCD_SK_PUSH: sp <= spDec;
								`CCD_SK_POP: sp <= spInc;
								`CCD_SK_RET, `CCD_SK_INTERRUPT_EXIT_OP: begin
									sp <= spInc;
									retHi <= rdData;
									state <= S_RET2;
								end
								`CCD_SK_LPM: begin
									lpmReg <= ir[11:7];
									state <= S_LPM;
								end
								`CCD_SK_SEI: status_flag_register[`CCD_F_I] <= 1'b1;
								`CCD_SK_CLI: status_flag_register[`CCD_F_I] <= 1'b0;
								default: begin
								end
							endcase
						end
					end
				end
				S_MUL: begin
					status_flag_register[`CCD_F_C] <= mulCarry;
					status_flag_register[`CCD_F_Z] <= mulProd == 16'h0000;
					state <= S_EXEC;
				end
				S_CALL2: begin
					sp <= spDec;
					pc <= target;
					irValid <= 1'b0;
					state <= S_EXEC;
				end
				S_RET2: begin
					sp <= spInc;
					pc <= {retHi, rdData};
					irValid <= 1'b0;
					state <= S_EXEC;
				end
				default: state <= S_EXEC;
			endcase
			// Low byte goes through the temporary so both halves change together
			if (memWe && ioSpl) begin
				spTemp <= memWdata;
			end
			if (memRe && ioSpl) begin
				spTemp <= sp[15:8];
			end
			if (memWe && ioSph) begin
				sp <= {memWdata, spTemp};
			end
			if (memWe && ioSreg) begin
				status_flag_register <= memWdata;
			end
			if (memWe && ioSpl) begin
				blockCnt <= `CCD_IRQ_BLOCK;
			end else if (ioWrite) begin
				blockCnt <= 3'h0;
			end else if (exec && (blockCnt != 3'h0)) begin
				blockCnt <= blockCnt - 3'h1;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/ccd_assertions.sv
// ccd_assertions.sv: port-level checks of the core datapath.
// Assumes it is bound to ccd_core and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "ccd_regs.vh"
module ccd_assertions (
	input wire mclk,
	input wire rst,
	input wire [15:0] progAddr,
	input wire [15:0] progData,
	input wire [15:0] dataAddr,
	input wire [7:0] dataWdata,
	input wire dataWe,
	input wire dataRe,
	input wire [7:0] dataRdata,
	input wire irqReq,
	input wire [15:0] irqVector,
	input wire irqAck,
	input wire irqReturn,
	input wire [7:0] statusFlags,
	input wire [15:0] stackPointer
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// An upper-byte access may load any value, so steps are judged outside it
	wire hiSel = dataAddr == `CCD_IO_SPH;
	// ****************
	// Stack traffic
	// ****************
	sequence push_byte;
		dataWe && dataAddr == stackPointer;
	endsequence
	sequence pop_byte;
		dataRe && dataAddr == stackPointer + 16'h0001;
	endsequence
	chk_reset_state: assert property (disable iff (1'b0)
		rst |-> progAddr == `CCD_PC_RESET && stackPointer == `CCD_SP_RESET && statusFlags == 8'h00)
		else $error("reset state wrong");
	chk_first_fetch: assert property (
		$fell(rst) |-> progAddr == 16'h0000 ##1 progAddr == 16'h0001)
		else $error("fetch after reset not sequential");
	chk_sp_down: assert property (
		stackPointer == $past(stackPointer) - 16'h0001 && !$past(hiSel)
		|-> $past(dataWe) && $past(dataAddr) == $past(stackPointer))
		else $error("stack decrement without store");
	chk_sp_up: assert property (
		stackPointer == $past(stackPointer) + 16'h0001 && !$past(hiSel)
		|-> $past(dataRe) && $past(dataAddr) == stackPointer)
		else $error("stack increment without load");
	chk_sp_step: assert property (
		!$past(hiSel) && !$stable(stackPointer) |-> stackPointer == $past(stackPointer) + 16'h0001
		|| stackPointer == $past(stackPointer) - 16'h0001)
		else $error("stack pointer step not one");
	chk_irq_push: assert property (
		irqAck |-> irqReq && statusFlags[`CCD_F_I] ##0 push_byte ##1 push_byte)
		else $error("interrupt entry push wrong");
	chk_irq_vector: assert property (
		irqAck |-> ##2 progAddr == $past(irqVector, 2))
		else $error("interrupt target not fetched");
	chk_irq_flags: assert property (
		irqAck |=> $stable(statusFlags) [*2])
		else $error("flags changed on interrupt entry");
	chk_ret_pop: assert property (
		irqReturn |-> pop_byte ##1 pop_byte ##1 stackPointer == $past(stackPointer, 2) + 16'h0002)
		else $error("interrupt return pop wrong");
	chk_core_io: assert property (
		dataAddr >= `CCD_IO_SPL && dataAddr <= `CCD_IO_STATUS_FLAG_REGISTER |-> !dataWe && !dataRe)
		else $error("core register reached the data bus");
endmodule
bind ccd_core ccd_assertions i_ccd_assertions (.mclk(mclk), .rst(rst), .progAddr(progAddr),
	.progData(progData), .dataAddr(dataAddr), .dataWdata(dataWdata), .dataWe(dataWe),
	.dataRe(dataRe), .dataRdata(dataRdata), .irqReq(irqReq), .irqVector(irqVector),
	.irqAck(irqAck), .irqReturn(irqReturn), .statusFlags(statusFlags),
	.stackPointer(stackPointer));
`default_nettype wire

// file: tb/ccd_mem_model.sv
// ccd_mem_model.sv: program ROM and data SRAM beside the core.
// Assumes asynchronous reads; the bench loads the ROM image directly.
`timescale 1ns/1ps
`default_nettype none
module ccd_mem_model (
	input wire logic mclk,
	input wire logic [15:0] progAddr,
	output logic [15:0] progData,
	input wire logic [15:0] dataAddr,
	input wire logic [7:0] dataWdata,
	input wire logic dataWe,
	input wire logic dataRe,
	output logic [7:0] dataRdata
);
	logic [15:0] rom [0:255];
	logic [7:0] ram [0:16383];
	logic [7:0] lastRd = 8'h00;
	assign progData = rom[progAddr[7:0]];
	// Unselected bus shows the inverse of the last read, never a stale copy
	assign dataRdata = dataRe ? ram[dataAddr[13:0]] : ~lastRd;
	always @(posedge mclk) begin
		if (dataRe === 1'b1)
			lastRd <= dataRdata;
		if (dataWe === 1'b1)
			ram[dataAddr[13:0]] <= dataWdata;
	end
endmodule
`default_nettype wire

// file: tb/ccd_core_tb_top.sv
// ccd_core_tb_top.sv: self-checking bench of the core datapath.
// Assumes the memory model beside the core and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "ccd_regs.vh"
module ccd_core_tb_top;
	logic mclk, rst, irqReq, isMul;
	logic [15:0] irqVector;
	logic [7:0] cyc;
	logic [63:0] r;
	wire [15:0] progAddr, progData, dataAddr, stackPointer;
	wire [7:0] dataWdata, dataRdata, statusFlags;
	wire dataWe, dataRe, irqAck, irqReturn;
	int err_total = 0;
	int cmp_count = 0;
	int tcnt = 0;
	logic [31:0] wrQ [$];
	// Row: opcode, first operand, second operand, pushed bytes, flag mask, flags
	logic [63:0] rows [0:22] = '{64'h0844_7F01_0180_0704, 64'h0844_FF01_0100_0703,
		64'h0845_8080_8000_0501, 64'h0846_1020_20F0_0705, 64'h0846_3333_3300_0702,
		64'h0847_0001_01FF_0505, 64'h1844_F00F_0F00_0602, 64'h1845_8001_0181_0604,
		64'h1846_AAFF_FF55_0600, 64'h1847_1234_3434_0000, 64'h2844_0102_0201_0705,
		64'h4007_0507_07FE_0705, 64'h5009_0909_0900_0500, 64'h6040_4040_4040_0702,
		64'h700F_3C0F_0F0C_0600, 64'h8000_0000_0000_0602, 64'h9055_0055_5555_0000,
		64'h3010_FFFF_FE01_0301, 64'h3011_FFFF_0001_0300, 64'h3012_FFFF_FF01_0301,
		64'h3013_8080_8000_0300, 64'h3014_C040_E000_0301, 64'h3015_FF80_FF00_0301};
	// Two calls in turn, the second through the Z pair, then a push and a halt
	logic [15:0] callProg [0:8] = '{16'h90A5, 16'h9E08, 16'h9F00, 16'hC004, 16'hB040,
		16'hB800, 16'hE6FF, 16'hF000, 16'hB020};
	// Low stack byte written (held in the temporary only), then a handler at 8
	logic [15:0] irqProg [0:10] = '{16'h9A3D, 16'h9010, 16'hA840, 16'hB060, 16'hF000,
		16'hF000, 16'hF000, 16'hE6FF, 16'hB800, 16'hB890, 16'hB030};
	// X at 0x0100: two post-increment stores, a pre-decrement, a displacement, then push X low
	logic [15:0] ptrProg [0:9] = '{16'h9B01, 16'h9A00, 16'h905A, 16'hA844, 16'hA844,
		16'hA848, 16'hA84C, 16'h0020, 16'hBD00, 16'hE6FF};

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	ccd_core i_ccd_core (.mclk(mclk), .rst(rst), .progAddr(progAddr), .progData(progData),
		.dataAddr(dataAddr), .dataWdata(dataWdata), .dataWe(dataWe), .dataRe(dataRe),
		.dataRdata(dataRdata), .irqReq(irqReq), .irqVector(irqVector), .irqAck(irqAck),
		.irqReturn(irqReturn), .statusFlags(statusFlags), .stackPointer(stackPointer));
	ccd_mem_model i_ccd_mem_model (.mclk(mclk), .progAddr(progAddr), .progData(progData),
		.dataAddr(dataAddr), .dataWdata(dataWdata), .dataWe(dataWe), .dataRe(dataRe),
		.dataRdata(dataRdata));

	// ****************
	// Monitor and watchdog
	// ****************
	always @(posedge mclk) begin
		cyc <= rst ? 8'h00 : cyc + 8'h01;
		if (dataWe === 1'b1)
			wrQ.push_back({cyc, dataAddr, dataWdata});
		// One interrupt per test; a held request would re-enter after return
		if (irqAck === 1'b1)
			irqReq <= 1'b0;
		tcnt <= tcnt + 1;
		if (tcnt == 3000) begin
			err_total = err_total + 1;
			results();
		end
	end

	task automatic chk_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count = cmp_count + 1;
		if (g !== e) begin
			err_total = err_total + 1;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Cycle field zero means the write's cycle is not of interest
	task automatic chk_bus(input string nm, input logic [31:0] e);
		logic [31:0] g;
		g = wrQ.size() > 0 ? wrQ.pop_front() : 32'hXXXXXXXX;
		if (e[31:24] == 8'h00)
			g[31:24] = 8'h00;
		cmp_count = cmp_count + 1;
		if (g !== e) begin
			err_total = err_total + 1;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic clr();
		for (int i = 0; i < 256; i++)
			i_ccd_mem_model.rom[i] = `CCD_OP_NOP;
		wrQ.delete();
	endtask

	task automatic run(input int n);
		rst <= 1'b1;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		repeat (n) @(posedge mclk);
	endtask

	task automatic results();
		if (err_total == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ****************
	// Main sequence
	// ****************
	initial begin
		rst = 1'b1;
		irqReq = 1'b0;
		irqVector = 16'h0000;
		repeat (4) @(posedge mclk);
		foreach (rows[i]) begin
			r = rows[i];
			isMul = r[63:60] == `CCD_OP_MUL;
			clr();
			i_ccd_mem_model.rom[0] = {4'h9, 4'h0, r[47:40]};
			i_ccd_mem_model.rom[1] = {4'h9, 4'h1, r[39:32]};
			i_ccd_mem_model.rom[2] = r[63:48];
			i_ccd_mem_model.rom[3] = isMul ? 16'hB080 : 16'hB880;
			i_ccd_mem_model.rom[4] = isMul ? 16'hB000 : 16'hB800;
			run(12);
			chk_bus("firstPush", {8'h04 + isMul, 16'h3FFF, r[31:24]});
			chk_bus("secondPush", {8'h05 + isMul, 16'h3FFE, r[23:16]});
			chk_reg("flags", {8'h00, r[7:0]}, {8'h00, statusFlags & r[15:8]});
			chk_reg("stackPtr", 16'h3FFD, stackPointer);
		end
		rst <= 1'b1;
		repeat (4) @(posedge mclk);
		chk_reg("resetFetch", 16'h0000, progAddr);
		chk_reg("resetStack", 16'h3FFF, stackPointer);
		chk_reg("resetFlags", 16'h0000, {8'h00, statusFlags});
		clr();
		foreach (callProg[i])
			i_ccd_mem_model.rom[i] = callProg[i];
		run(30);
		chk_bus("callLow", {8'h00, 16'h3FFF, 8'h04});
		chk_bus("callHigh", {8'h00, 16'h3FFE, 8'h00});
		chk_bus("zCallLow", {8'h00, 16'h3FFF, 8'h05});
		chk_bus("zCallHigh", {8'h00, 16'h3FFE, 8'h00});
		chk_bus("afterReturn", {8'h00, 16'h3FFF, 8'hA5});
		chk_reg("callStack", 16'h3FFE, stackPointer);
		clr();
		foreach (ptrProg[i])
			i_ccd_mem_model.rom[i] = ptrProg[i];
		run(20);
		chk_bus("postInc1", {8'h00, 16'h0100, 8'h5A});
		chk_bus("postInc2", {8'h00, 16'h0101, 8'h5A});
		chk_bus("preDec", {8'h00, 16'h0101, 8'h5A});
		chk_bus("dispStore", {8'h00, 16'h0121, 8'h5A});
		chk_bus("ptrLow", {8'h00, 16'h3FFF, 8'h01});
		chk_reg("ptrStack", 16'h3FFE, stackPointer);
		clr();
		foreach (irqProg[i])
			i_ccd_mem_model.rom[i] = irqProg[i];
		irqVector <= 16'h0008;
		irqReq <= 1'b1;
		run(30);
		chk_bus("irqLow", {8'h00, 16'h3FFF, 8'h07});
		chk_bus("irqHigh", {8'h00, 16'h3FFE, 8'h00});
		chk_bus("handlerPush", {8'h00, 16'h3FFD, 8'h10});
		chk_reg("strayWrites", 16'h0000, 16'(wrQ.size()));
		chk_reg("irqStack", 16'h3FFF, stackPointer);
		chk_reg("irqFlags", 16'h0080, {8'h00, statusFlags});
		results();
	end
endmodule
`default_nettype wire
